// ===== bench/bpg_line_model.sv
`default_nettype none
module bpg_line_model (
	input wire logic line_clock,
	input wire logic tx_data,
	output logic rx_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// Looped line: each transmitted bit comes back one line clock later
	always @(posedge line_clock) begin
		rx_data <= tx_data;
	end
endmodule
`default_nettype wire

// ===== bench/test_bpg_top.sv
`default_nettype none
`include "bpg_params.svh"
module test_bpg_top
	import bpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic line_clock = 1'b0;
	logic sys_rst = 1'b1;
	bpg_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata;
	logic external_update_signal = 1'b0;
	logic external_error_trigger = 1'b0;
	logic rx_data;
	logic tx_data;
	logic update_complete_flag;
	logic rx_out_of_sync;
	int err_total = 0;
	int tests_run = 0;
	int seed = 32'h0D08;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	logic rd_seen = 1'b0;
	logic [7:0] ctl = 8'h00;
	logic bits[$];
	int pos[$];
	logic [31:0] pat;
	logic [31:0] w;
	logic hit;

	always #20 clock = ~clock;
	initial begin
		#7;
		forever #40 line_clock = ~line_clock;
	end

	bpg_top bpg_top_i (
		.clock(clock),
		.sys_rst(sys_rst),
		.tx_side_clock(line_clock),
		.rx_side_clock(line_clock),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.external_update_signal(external_update_signal),
		.external_error_trigger(external_error_trigger),
		.rx_data(rx_data),
		.tx_data(tx_data),
		.update_complete_flag(update_complete_flag),
		.rx_out_of_sync(rx_out_of_sync)
	);
	bpg_line_model bpg_line_model_i (
		.line_clock(line_clock),
		.tx_data(tx_data),
		.rx_data(rx_data)
	);

	task automatic end_sim();
		$display("checks %0d, errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string s, input logic [31:0] x,
		input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("unexpected %s: expected %0h, seen %0h", s, x, g);
		end
	endtask

	// Read data is valid one cycle after the read strobe
	always @(posedge clock)
		rd_seen <= reg_req.rd;
	always @(negedge clock) begin
		if (rd_seen) begin
			e = exp_q.pop_front();
			check("register read", e[7:0], reg_rdata & e[15:8]);
		end
	end

	task automatic wr(input int a, input logic [7:0] d);
		@(posedge clock);
		reg_req <= '{addr: a[7:0], wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clock);
		reg_req.wr <= 1'b0;
	endtask

	task automatic rd(input int a, input logic [7:0] x,
		input logic [7:0] m);
		exp_q.push_back({m, x});
		@(posedge clock);
		reg_req <= '{addr: a[7:0], wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clock);
		reg_req.rd <= 1'b0;
	endtask

	task automatic setc(input int b, input logic v);
		ctl[b] = v;
		wr(`BPG_OFS_CONTROL, ctl);
	endtask

	// Pattern fields stay untouched for eight line clocks after a load
	task automatic load(input logic [7:0] m);
		wr(`BPG_OFS_CONTROL, ctl | m);
		wr(`BPG_OFS_CONTROL, ctl);
		repeat (8) @(posedge line_clock);
	endtask

	task automatic wait_for(input int f, input logic v, input int lim);
		int n = 0;
		while ((f ? update_complete_flag : rx_out_of_sync) !== v) begin
			@(posedge clock);
			n++;
			if (n > lim) begin
				check("timeout", v, f ? update_complete_flag : rx_out_of_sync);
				end_sim();
			end
		end
		check(f ? "update flag" : "out of sync", v,
			f ? update_complete_flag : rx_out_of_sync);
	endtask

	task automatic grab(input int n);
		bits.delete();
		pos.delete();
		for (int i = 0; i < n; i++) begin
			@(negedge line_clock);
			bits.push_back(tx_data);
			if (tx_data === 1'b1)
				pos.push_back(i);
		end
	endtask

	// Stream must follow a two-tap recurrence of order n, either bit order
	task automatic lfsr_chk(input string s, input int n, input int y,
		input int lim);
		int b1 = 0;
		int b2 = 0;
		grab(n + 200);
		for (int t = n; t < n + 200; t++) begin
			if ((bits[t] ^ bits[t-n] ^ bits[t-y]) !== 1'b0)
				b1++;
			if ((bits[t] ^ bits[t-n] ^ bits[t-n+y]) !== 1'b0)
				b2++;
		end
		check(s, 1, (b1 <= lim || b2 <= lim) && pos.size() > 20 &&
			pos.size() < n + 180);
	endtask

	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		for (int a = 0; a < 9; a++)
			rd(a, 8'h00, 8'hFF);
		rd(`BPG_OFS_STATUS, 8'h01, 8'h09);
		pat = $random(seed);
		pat[0] = 1'b1;
		for (int i = 0; i < 4; i++)
			wr(`BPG_OFS_SEED0 + i, pat[8*i +: 8]);
		for (int i = 0; i < 4; i++)
			rd(`BPG_OFS_SEED0 + i, pat[8*i +: 8], 8'hFF);
		wr(`BPG_OFS_CFG_ONE, 8'h3F);
		load(8'h02);
		grab(64);
		hit = 1'b0;
		for (int k = 0; k < 32; k++) begin
			for (int i = 0; i < 32; i++)
				w = {w[30:0], bits[k+i]};
			if (w === pat)
				hit = 1'b1;
		end
		check("repeat order", 1, hit);
		wr(`BPG_OFS_CFG_ONE, 8'h06);
		wr(`BPG_OFS_CFG_TWO, 8'h05);
		load(8'h02);
		lfsr_chk("prbs seven", 7, 6, 0);
		wr(`BPG_OFS_CFG_ONE, 8'h46);
		load(8'h02);
		lfsr_chk("quasi random", 20, 17, 12);
		for (int i = 0; i < 4; i++)
			wr(`BPG_OFS_SEED0 + i, 8'h00);
		wr(`BPG_OFS_CFG_ONE, 8'h3F);
		load(8'h22);
		wait_for(0, 1'b0, 8000);
		grab(40);
		check("zero stream", 0, pos.size());
		setc(`BPG_CTL_TX_INV, 1'b1);
		repeat (6) @(posedge line_clock);
		grab(40);
		check("inverted stream", 40, pos.size());
		wait_for(0, 1'b1, 400);
		setc(`BPG_CTL_RX_INV, 1'b1);
		wait_for(0, 1'b0, 8000);
		setc(`BPG_CTL_AUTO_DIS, 1'b1);
		setc(`BPG_CTL_TX_INV, 1'b0);
		repeat (200) @(posedge clock);
		check("sync held", 0, rx_out_of_sync);
		setc(`BPG_CTL_RESYNC, 1'b1);
		wait_for(0, 1'b1, 40);
		setc(`BPG_CTL_RESYNC, 1'b0);
		setc(`BPG_CTL_RX_INV, 1'b0);
		wait_for(0, 1'b0, 8000);
		load(8'h20);
		check("load forces hunt", 1, rx_out_of_sync);
		wait_for(0, 1'b0, 8000);
		wr(`BPG_OFS_ERR_CTL, 8'h02);
		grab(40);
		check("blocked error", 0, pos.size());
		wr(`BPG_OFS_ERR_CTL, 8'h04);
		wr(`BPG_OFS_ERR_CTL, 8'h06);
		grab(40);
		check("single error", 1, pos.size());
		wr(`BPG_OFS_ERR_CTL, 8'h04);
		wr(`BPG_OFS_ERR_CTL, 8'h05);
		wr(`BPG_OFS_ERR_CTL, 8'h07);
		grab(40);
		check("register ignored", 0, pos.size());
		wr(`BPG_OFS_ERR_CTL, 8'h05);
		@(posedge clock);
		external_error_trigger <= 1'b1;
		grab(40);
		check("pin error", 1, pos.size());
		@(posedge clock);
		external_error_trigger <= 1'b0;
		wr(`BPG_OFS_ERR_CTL, 8'h00);
		wr(`BPG_OFS_ERR_CTL, 8'h08);
		grab(120);
		hit = pos.size() >= 10;
		for (int i = 1; i < pos.size(); i++)
			if (pos[i] - pos[i-1] != 10)
				hit = 1'b0;
		check("rate one spacing", 1, hit);
		for (int i = 0; i < 20 && tx_data !== 1'b1; i++)
			@(negedge line_clock);
		wr(`BPG_OFS_ERR_CTL, 8'h10);
		grab(240);
		check("old rate kept", 1, pos.size() >= 2 && pos[0] < 10);
		check("new rate gap", 100, pos[1] - pos[0]);
		wr(`BPG_OFS_ERR_CTL, 8'h00);
		grab(240);
		check("rate off", 1, pos.size() <= 1);
		setc(`BPG_CTL_LOCAL_UPD, 1'b1);
		wait_for(1, 1'b1, 60);
		setc(`BPG_CTL_LOCAL_UPD, 1'b0);
		@(negedge clock);
		check("flag drop", 0, update_complete_flag);
		setc(`BPG_CTL_UPD_MODE, 1'b1);
		setc(`BPG_CTL_LOCAL_UPD, 1'b1);
		repeat (60) @(posedge clock);
		check("local ignored", 0, update_complete_flag);
		setc(`BPG_CTL_LOCAL_UPD, 1'b0);
		@(posedge clock);
		external_update_signal <= 1'b1;
		wait_for(1, 1'b1, 60);
		@(posedge clock);
		external_update_signal <= 1'b0;
		repeat (4) @(posedge clock);
		check("pin flag drop", 0, update_complete_flag);
		rd(`BPG_OFS_CONTROL, 8'h84, 8'hFF);
		repeat (4) @(posedge clock);
		end_sim();
	end
endmodule
`default_nettype wire

// ===== design/bpg_top.sv
`default_nettype none
`include "bpg_params.svh"
module bpg_top
	import bpg_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic tx_side_clock,
	input wire logic rx_side_clock,
	input wire bpg_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic external_update_signal,
	input wire logic external_error_trigger,
	input wire logic rx_data,
	output logic tx_data,
	output logic update_complete_flag,
	output logic rx_out_of_sync
);
	function automatic bpg_cfg_t resolve_cfg(input bpg_cfg_t c);
		bpg_cfg_t r;
		r = c;
		if (c.quasi_random_enable) begin
			r.rep = 1'b0;
			r.len_idx = `BPG_QUASI_RANDOM_ENABLE_LEN_IDX;
			r.tap_idx = `BPG_QUASI_RANDOM_ENABLE_TAP_IDX;
			r.seed = 32'hFFFFFFFF;
		end
		return r;
	endfunction

	function automatic logic feedback(input logic [31:0] sr,
			input bpg_cfg_t c);
		feedback = c.rep ? sr[c.len_idx] : sr[c.len_idx] ^ sr[c.tap_idx];
	endfunction

	function automatic logic [23:0] period_of(input logic [2:0] rate);
		logic [23:0] p;
		p = 24'h000001;
		for (int i = 0; i < 7; i++) begin
			if (3'(i) < rate) begin
				p = 24'(p * 24'h00000A);
			end
		end
		return p;
	endfunction

	// Register file, system clock
	logic [7:0] ctl_ff, cfg_one_ff, cfg_two_ff, err_ctl_ff;
	logic [7:0] seed_ff [0:3];
	logic [7:0] ctl_prev_ff;
	logic sgl_prev_ff;
	logic [7:0] rdata_ff;
	logic upd_ff, oos_s1_ff, oos_s2_ff;
	bpg_cfg_t cfg_regs;

	assign cfg_regs = '{quasi_random_enable: cfg_one_ff[`BPG_CFG_QUASI_RANDOM_ENABLE],
		rep: cfg_one_ff[`BPG_CFG_TYPE], len_idx: cfg_one_ff[4:0],
		tap_idx: cfg_two_ff[4:0],
		seed: {seed_ff[3], seed_ff[2], seed_ff[1], seed_ff[0]}};
	bpg_cfg_t cfg_res;
	assign cfg_res = resolve_cfg(cfg_regs);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctl_ff <= `BPG_RST_VAL;
			cfg_one_ff <= `BPG_RST_VAL;
			cfg_two_ff <= `BPG_RST_VAL;
			err_ctl_ff <= `BPG_RST_VAL;
			for (int i = 0; i < 4; i++) begin
				seed_ff[i] <= `BPG_RST_VAL;
			end
		end else if (reg_req.wr) begin
			if (reg_req.addr == `BPG_OFS_CONTROL) begin
				ctl_ff <= reg_req.wdata;
			end else if (reg_req.addr == `BPG_OFS_CFG_ONE) begin
				cfg_one_ff <= {1'b0, reg_req.wdata[6:0]};
			end else if (reg_req.addr == `BPG_OFS_CFG_TWO) begin
				cfg_two_ff <= {3'h0, reg_req.wdata[4:0]};
			end else if (reg_req.addr >= `BPG_OFS_SEED0
					&& reg_req.addr <= `BPG_OFS_SEED3) begin
				seed_ff[reg_req.addr[1:0]] <= reg_req.wdata;
			end else if (reg_req.addr == `BPG_OFS_ERR_CTL) begin
				err_ctl_ff <= {2'h0, reg_req.wdata[5:0]};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_ff <= 8'h00;
		end else if (reg_req.rd) begin
			if (reg_req.addr == `BPG_OFS_CONTROL) begin
				rdata_ff <= ctl_ff;
			end else if (reg_req.addr == `BPG_OFS_CFG_ONE) begin
				rdata_ff <= cfg_one_ff;
			end else if (reg_req.addr == `BPG_OFS_CFG_TWO) begin
				rdata_ff <= cfg_two_ff;
			end else if (reg_req.addr >= `BPG_OFS_SEED0
					&& reg_req.addr <= `BPG_OFS_SEED3) begin
				rdata_ff <= seed_ff[reg_req.addr[1:0]];
			end else if (reg_req.addr == `BPG_OFS_ERR_CTL) begin
				rdata_ff <= err_ctl_ff;
			end else if (reg_req.addr == `BPG_OFS_STATUS) begin
				rdata_ff <= 8'h00;
				rdata_ff[`BPG_STS_PMS] <= update_complete_flag;
				rdata_ff[`BPG_STS_OOS] <= oos_s2_ff;
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end
	assign reg_rdata = rdata_ff;

	// Control edges, the single-error trigger edge and error-control writes become toggles for the link domains
	logic tx_load_tgl_ff, rx_load_tgl_ff, resync_tgl_ff, sgl_tgl_ff;
	logic rate_tgl_ff;
	logic [7:0] ctl_rise;
	logic sgl_rise;
	assign ctl_rise = ctl_ff & ~ctl_prev_ff;
	assign sgl_rise = err_ctl_ff[`BPG_ERR_SGL_TRIG] & ~sgl_prev_ff;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctl_prev_ff <= 8'h00;
			sgl_prev_ff <= 1'b0;
			tx_load_tgl_ff <= 1'b0;
			rx_load_tgl_ff <= 1'b0;
			resync_tgl_ff <= 1'b0;
			sgl_tgl_ff <= 1'b0;
			rate_tgl_ff <= 1'b0;
		end else begin
			ctl_prev_ff <= ctl_ff;
			sgl_prev_ff <= err_ctl_ff[`BPG_ERR_SGL_TRIG];
			tx_load_tgl_ff <= tx_load_tgl_ff ^ ctl_rise[`BPG_CTL_TX_LOAD];
			rx_load_tgl_ff <= rx_load_tgl_ff ^ ctl_rise[`BPG_CTL_RX_LOAD];
			resync_tgl_ff <= resync_tgl_ff ^ ctl_rise[`BPG_CTL_RESYNC];
			sgl_tgl_ff <= sgl_tgl_ff ^ (sgl_rise
				& ~err_ctl_ff[`BPG_ERR_SRC] & err_ctl_ff[`BPG_ERR_SGL_EN]);
			rate_tgl_ff <= rate_tgl_ff ^ (reg_req.wr
				& (reg_req.addr == `BPG_OFS_ERR_CTL));
		end
	end

	// Performance-monitoring update handshake with the receive side
	logic ext_upd_s1_ff, ext_upd_s2_ff, trig, trig_prev_ff;
	logic pm_req_tgl_ff, pm_ack_s1_ff, pm_ack_s2_ff, pm_ack_s3_ff;
	logic pm_done_ff;
	assign trig = ctl_ff[`BPG_CTL_UPD_MODE] ? ext_upd_s2_ff
		: ctl_ff[`BPG_CTL_LOCAL_UPD];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ext_upd_s1_ff <= 1'b0;
			ext_upd_s2_ff <= 1'b0;
			trig_prev_ff <= 1'b0;
			pm_req_tgl_ff <= 1'b0;
			pm_ack_s1_ff <= 1'b0;
			pm_ack_s2_ff <= 1'b0;
			pm_ack_s3_ff <= 1'b0;
			pm_done_ff <= 1'b0;
			oos_s1_ff <= 1'b1;
			oos_s2_ff <= 1'b1;
		end else begin
			ext_upd_s1_ff <= external_update_signal;
			ext_upd_s2_ff <= ext_upd_s1_ff;
			trig_prev_ff <= trig;
			pm_req_tgl_ff <= pm_req_tgl_ff ^ (trig & ~trig_prev_ff);
			pm_ack_s1_ff <= upd_ff;
			pm_ack_s2_ff <= pm_ack_s1_ff;
			pm_ack_s3_ff <= pm_ack_s2_ff;
			pm_done_ff <= (pm_ack_s2_ff ^ pm_ack_s3_ff) | (pm_done_ff & trig);
			oos_s1_ff <= rx_out_of_sync;
			oos_s2_ff <= oos_s1_ff;
		end
	end
	assign update_complete_flag = pm_done_ff & trig;

	// Transmit domain
	logic [1:0] tx_rst_ff;
	logic tx_rst;
	logic [2:0] tx_load_s_ff, sgl_s_ff, rate_s_ff, ext_err_s_ff;
	logic [3:0] tx_lvl_s1_ff, tx_lvl_s2_ff;
	bpg_cfg_t tx_cfg_ff;
	logic [31:0] tx_sr_ff;
	logic [23:0] rate_cnt_ff;
	logic [2:0] rate_act_ff, rate_pend_ff;
	logic rate_pend_vld_ff, sgl_pend_ff, tx_out, rate_hit, ext_rise;
	assign tx_rst = tx_rst_ff[1];

	always_ff @(posedge tx_side_clock) begin
		tx_rst_ff <= {tx_rst_ff[0], sys_rst};
		tx_load_s_ff <= {tx_load_s_ff[1:0], tx_load_tgl_ff};
		sgl_s_ff <= {sgl_s_ff[1:0], sgl_tgl_ff};
		rate_s_ff <= {rate_s_ff[1:0], rate_tgl_ff};
		ext_err_s_ff <= {ext_err_s_ff[1:0], external_error_trigger};
		tx_lvl_s1_ff <= {err_ctl_ff[`BPG_ERR_SGL_EN],
			err_ctl_ff[`BPG_ERR_SRC], ctl_ff[`BPG_CTL_TX_INV], 1'b0};
		tx_lvl_s2_ff <= tx_lvl_s1_ff;
	end

	// Quasi-random output forced high when the next run would be all zero
	assign tx_out = tx_sr_ff[tx_cfg_ff.len_idx] | (tx_cfg_ff.quasi_random_enable
		& (tx_sr_ff[19 -: `BPG_QUASI_RANDOM_ENABLE_ZERO_RUN] == 14'h0000));
	assign rate_hit = (rate_act_ff != 3'h0)
		& (rate_cnt_ff == 24'(period_of(rate_act_ff) - 24'h000001));
	assign ext_rise = ext_err_s_ff[1] & ~ext_err_s_ff[2];

	always_ff @(posedge tx_side_clock) begin
		if (tx_rst) begin
			tx_cfg_ff <= '0;
			tx_sr_ff <= 32'h00000000;
		end else if (tx_load_s_ff[1] ^ tx_load_s_ff[2]) begin
			tx_cfg_ff <= cfg_res;
			tx_sr_ff <= cfg_res.seed;
		end else begin
			tx_sr_ff <= {tx_sr_ff[30:0], feedback(tx_sr_ff, tx_cfg_ff)};
		end
	end

	always_ff @(posedge tx_side_clock) begin
		if (tx_rst) begin
			rate_cnt_ff <= 24'h000000;
			rate_act_ff <= 3'h0;
			rate_pend_ff <= 3'h0;
			rate_pend_vld_ff <= 1'b0;
		end else begin
			if (rate_hit) begin
				rate_cnt_ff <= 24'h000000;
				if (rate_pend_vld_ff) begin
					rate_act_ff <= rate_pend_ff;
				end
			end else if (rate_act_ff != 3'h0) begin
				rate_cnt_ff <= rate_cnt_ff + 24'h000001;
			end
			if (rate_s_ff[1] ^ rate_s_ff[2]) begin
				if (rate_act_ff == 3'h0) begin
					rate_act_ff <= err_ctl_ff[`BPG_ERR_RATE_HI:`BPG_ERR_RATE_LO];
					rate_cnt_ff <= 24'h000000;
					rate_pend_vld_ff <= 1'b0;
				end else begin
					rate_pend_ff <= err_ctl_ff[`BPG_ERR_RATE_HI:`BPG_ERR_RATE_LO];
					rate_pend_vld_ff <= 1'b1;
				end
			end else if (rate_hit) begin
				rate_pend_vld_ff <= 1'b0;
			end
		end
	end

	// Every transmit bit is an insertion chance, so one pending flag suffices
	always_ff @(posedge tx_side_clock) begin
		if (tx_rst) begin
			sgl_pend_ff <= 1'b0;
			tx_data <= 1'b0;
		end else begin
			sgl_pend_ff <= (sgl_s_ff[1] ^ sgl_s_ff[2])
				| (ext_rise & tx_lvl_s2_ff[3] & tx_lvl_s2_ff[2]);
			tx_data <= tx_out ^ tx_lvl_s2_ff[1]
				^ (rate_hit | sgl_pend_ff);
		end
	end

	// Receive domain
	logic [1:0] rx_rst_ff;
	logic rx_rst;
	logic [2:0] rx_load_s_ff, resync_s_ff;
	logic [1:0] rx_lvl_s1_ff, rx_lvl_s2_ff, rx_din_ff;
	logic pm_req_s1_ff, pm_req_s2_ff;
	bpg_cfg_t rx_cfg_ff;
	bpg_rx_state_t rx_state_ff;
	logic [31:0] rx_sr_ff;
	logic [5:0] match_cnt_ff, win_cnt_ff;
	logic [2:0] miss_cnt_ff;
	logic rx_in, rx_exp, rx_miss, rx_load_ev, resync_ev, auto_drop;
	assign rx_rst = rx_rst_ff[1];
	assign rx_load_ev = rx_load_s_ff[1] ^ rx_load_s_ff[2];
	assign resync_ev = resync_s_ff[1] ^ resync_s_ff[2];
	assign rx_in = rx_din_ff[1] ^ rx_lvl_s2_ff[1];
	assign rx_exp = feedback(rx_sr_ff, rx_cfg_ff);
	assign rx_miss = rx_in != rx_exp;
	assign auto_drop = ~rx_lvl_s2_ff[0] & rx_miss
		& (miss_cnt_ff == 3'(`BPG_MISMATCH_LIMIT - 3'h1));

	always_ff @(posedge rx_side_clock) begin
		rx_rst_ff <= {rx_rst_ff[0], sys_rst};
		rx_load_s_ff <= {rx_load_s_ff[1:0], rx_load_tgl_ff};
		resync_s_ff <= {resync_s_ff[1:0], resync_tgl_ff};
		rx_lvl_s1_ff <= {ctl_ff[`BPG_CTL_RX_INV], ctl_ff[`BPG_CTL_AUTO_DIS]};
		rx_lvl_s2_ff <= rx_lvl_s1_ff;
		rx_din_ff <= {rx_din_ff[0], rx_data};
		pm_req_s1_ff <= pm_req_tgl_ff;
		pm_req_s2_ff <= pm_req_s1_ff;
	end

	always_ff @(posedge rx_side_clock) begin
		if (rx_rst) begin
			upd_ff <= 1'b0;
		end else begin
			upd_ff <= pm_req_s2_ff;
		end
	end

	always_ff @(posedge rx_side_clock) begin
		if (rx_rst) begin
			rx_cfg_ff <= '0;
			rx_state_ff <= BPG_OOS;
			rx_sr_ff <= 32'h00000000;
			match_cnt_ff <= 6'h00;
			win_cnt_ff <= 6'h00;
			miss_cnt_ff <= 3'h0;
		end else if (rx_load_ev) begin
			rx_cfg_ff <= cfg_res;
			rx_sr_ff <= cfg_res.seed;
			rx_state_ff <= BPG_OOS;
			match_cnt_ff <= 6'h00;
		end else begin
			case (rx_state_ff)
				BPG_OOS: begin
					// Repetitive hunt slips one bit on a miss
					if (rx_miss) begin
						match_cnt_ff <= 6'h00;
						if (!rx_cfg_ff.rep) begin
							rx_sr_ff <= {rx_sr_ff[30:0], rx_in};
						end
					end else begin
						rx_sr_ff <= {rx_sr_ff[30:0], rx_exp};
						match_cnt_ff <= match_cnt_ff + 6'h01;
						if (match_cnt_ff == 6'(`BPG_SYNC_MATCHES - 6'h01)) begin
							rx_state_ff <= BPG_SYNC;
							win_cnt_ff <= 6'h00;
							miss_cnt_ff <= 3'h0;
						end
					end
				end
				BPG_SYNC: begin
					rx_sr_ff <= {rx_sr_ff[30:0], rx_exp};
					win_cnt_ff <= win_cnt_ff + 6'h01;
					if (win_cnt_ff == `BPG_WIN_LAST) begin
						miss_cnt_ff <= 3'h0;
					end else if (rx_miss && miss_cnt_ff != 3'h7) begin
						miss_cnt_ff <= miss_cnt_ff + 3'h1;
					end
					if (resync_ev || auto_drop) begin
						rx_state_ff <= BPG_OOS;
						match_cnt_ff <= 6'h00;
					end
				end
				default: begin
					rx_state_ff <= BPG_OOS;
				end
			endcase
		end
	end
	assign rx_out_of_sync = (rx_state_ff == BPG_OOS);

	a_flag_needs_trig: assert property (@(posedge clock) disable iff (sys_rst)
		update_complete_flag |-> trig) else $error("flag without trigger");
	a_local_ignored: assert property (@(posedge clock) disable iff (sys_rst)
		ctl_ff[`BPG_CTL_UPD_MODE] && $rose(ctl_ff[`BPG_CTL_LOCAL_UPD])
		&& $stable(ext_upd_s2_ff) |=> $stable(pm_req_tgl_ff))
		else $error("local update acted in external mode");
	a_update_done: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(trig) ##1 trig[*8] |-> ##[0:40] update_complete_flag || !trig)
		else $error("update never completed");
	a_rx_load_oos: assert property (@(posedge rx_side_clock)
		disable iff (rx_rst) rx_load_ev |=> rx_out_of_sync)
		else $error("load left receiver in sync");
	a_resync_oos: assert property (@(posedge rx_side_clock)
		disable iff (rx_rst) resync_ev && rx_state_ff == BPG_SYNC
		|=> rx_out_of_sync) else $error("resync ignored");
	a_auto_drop: assert property (@(posedge rx_side_clock)
		disable iff (rx_rst) rx_state_ff == BPG_SYNC && !rx_load_ev
		&& !resync_ev && rx_lvl_s2_ff[0] |=> rx_state_ff == BPG_SYNC)
		else $error("left sync with auto resync off");
	a_six_misses: assert property (@(posedge rx_side_clock)
		disable iff (rx_rst) rx_state_ff == BPG_SYNC && !rx_lvl_s2_ff[0]
		&& rx_miss && miss_cnt_ff == 3'h5 && win_cnt_ff != `BPG_WIN_LAST
		|=> rx_out_of_sync) else $error("no drop on six misses");
	a_tx_invert: assert property (@(posedge tx_side_clock)
		disable iff (tx_rst) !rate_hit && !sgl_pend_ff
		|=> tx_data == ($past(tx_out) ^ $past(tx_lvl_s2_ff[1])))
		else $error("transmit bit wrong");
	a_quasi_random_enable_force: assert property (@(posedge tx_side_clock)
		disable iff (tx_rst) tx_cfg_ff.quasi_random_enable && tx_sr_ff[19:6] == 14'h0000
		|-> tx_out) else $error("zero run not forced");
	a_one_error: assert property (@(posedge tx_side_clock)
		disable iff (tx_rst) sgl_pend_ff && !(sgl_s_ff[1] ^ sgl_s_ff[2])
		&& !ext_rise |=> !sgl_pend_ff) else $error("error repeated");
	c_sync_reached: cover property (@(posedge rx_side_clock)
		rx_state_ff == BPG_OOS ##1 rx_state_ff == BPG_SYNC);
	c_rate_error: cover property (@(posedge tx_side_clock) rate_hit);
	c_update_done: cover property (@(posedge clock)
		$rose(update_complete_flag));
endmodule
`default_nettype wire

// ===== pkg/bpg_params.svh
`ifndef BPG_PARAMS_SVH
`define BPG_PARAMS_SVH

`define BPG_OFS_CONTROL 8'h00
`define BPG_OFS_CFG_ONE 8'h02
`define BPG_OFS_CFG_TWO 8'h03
`define BPG_OFS_SEED0 8'h04
`define BPG_OFS_SEED1 8'h05
`define BPG_OFS_SEED2 8'h06
`define BPG_OFS_SEED3 8'h07
`define BPG_OFS_ERR_CTL 8'h08
`define BPG_OFS_STATUS 8'h0C
`define BPG_RST_VAL 8'h00

`define BPG_CTL_UPD_MODE 7
`define BPG_CTL_LOCAL_UPD 6
`define BPG_CTL_RX_LOAD 5
`define BPG_CTL_RX_INV 4
`define BPG_CTL_RESYNC 3
`define BPG_CTL_AUTO_DIS 2
`define BPG_CTL_TX_LOAD 1
`define BPG_CTL_TX_INV 0

`define BPG_CFG_QUASI_RANDOM_ENABLE 6
`define BPG_CFG_TYPE 5
`define BPG_ERR_RATE_HI 5
`define BPG_ERR_RATE_LO 3
`define BPG_ERR_SGL_EN 2
`define BPG_ERR_SGL_TRIG 1
`define BPG_ERR_SRC 0
`define BPG_STS_PMS 3
`define BPG_STS_OOS 0

`define BPG_QUASI_RANDOM_ENABLE_LEN_IDX 5'h13
`define BPG_QUASI_RANDOM_ENABLE_TAP_IDX 5'h10
`define BPG_QUASI_RANDOM_ENABLE_ZERO_RUN 14
`define BPG_WIN_LAST 6'h3F
`define BPG_MISMATCH_LIMIT 3'h6
`define BPG_SYNC_MATCHES 6'h20

`endif

// ===== pkg/bpg_pkg.sv
`default_nettype none
package bpg_pkg;
	typedef struct packed {
		logic quasi_random_enable;
		logic rep;
		logic [4:0] len_idx;
		logic [4:0] tap_idx;
		logic [31:0] seed;
	} bpg_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} bpg_reg_req_t;

	typedef enum logic {
		BPG_OOS = 1'b0,
		BPG_SYNC = 1'b1
	} bpg_rx_state_t;
endpackage
`default_nettype wire
